// ---- shared/timer_map.svh ----
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define CTRL_IDX      8'h88
`define MODE_IDX      8'h89
`define LO0_IDX       8'h8a
`define LO1_IDX       8'h8b
`define HI0_IDX       8'h8c
`define HI1_IDX       8'h8d
`define IRQ_STAT_IDX  8'h90
`define IRQ_EN_IDX    8'h91
`define IRQ_CLR_IDX   8'h92

// ****************************************
// reset values
// ****************************************
`define CTRL_RST      8'h00
`define MODE_RST      8'h00
`define CNT_RST       8'h00
`define IRQ_RST       4'h0

// ****************************************
// interrupt status layout, also vector acknowledge layout
// ****************************************
`define ST_EXA        0
`define ST_EXB        1
`define ST_OVF0       2
`define ST_OVF1       3

// ****************************************
// timing
// ****************************************
`define MCYC_LAST     4'hb
`define PRESC_MSB     4
`define PRESC_ALL     5'h1f

`endif

// ---- shared/timer_pkg.sv ----
package timer_pkg;

   // ****************************************
   // operating modes, in field order 00..11
   // ****************************************
   typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} timer_mode_e;

   typedef struct packed {
      logic        gate_ctl;
      logic        counter_sel;
      timer_mode_e mode_sel;
   } mode_half_s;

   typedef struct packed {
      mode_half_s second;
      mode_half_s first;
   } timer_mode_select_reg_s;

   typedef struct packed {
      logic second_overflow_flag;
      logic second_run_bit;
      logic first_overflow_flag;
      logic first_run_bit;
      logic ext_irq_b_pending;
      logic ext_irq_b_trigger_sel;
      logic ext_irq_a_pending;
      logic ext_irq_a_trigger_sel;
   } timer_run_and_irq_control_s;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [9:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_s;

endpackage

// ---- logic/pin_sampler.sv ----
`timescale 1ns/1ps
`include "timer_map.svh"

module pin_sampler (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic tick_i,
   input  wire logic pin_i,
   output logic      low_o,
   output logic      fell_o
);

   typedef struct packed {
      logic cur;
      logic fell;
   } smp_s;

   smp_s q, n;

   // one sample per machine cycle; a fall is high then low in two samples
   always_comb begin
      n = q;
      n.fell = 1'b0;
      if (tick_i) begin
         n.cur  = pin_i;
         n.fell = q.cur & ~pin_i;
      end
   end

   // idle level of the pins is high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '{cur: 1'b1, fell: 1'b0};
      end else begin
         q <= n;
      end
   end

   assign low_o  = ~q.cur;
   assign fell_o = q.fell;

endmodule

// ---- logic/count_unit.sv ----
`timescale 1ns/1ps
`include "timer_map.svh"

module count_unit
   import timer_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  timer_mode_e      mode_i,
   input  wire logic        inc_i,
   input  wire logic        inc_hi_i,
   input  wire logic        wr_lo_i,
   input  wire logic        wr_hi_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  lo_o,
   output logic      [7:0]  hi_o,
   output logic             ovf_o,
   output logic             ovf_hi_o
);

   typedef struct packed {
      logic [7:0] lo;
      logic [7:0] hi;
      logic       ovf;
      logic       ovf_hi;
   } cnt_s;

   cnt_s q, n;

   // ****************************************
   // count paths per mode
   // ****************************************
   always_comb begin
      n = q;
      n.ovf    = 1'b0;
      n.ovf_hi = 1'b0;
      case (mode_i)
         MODE_13BIT: begin
            // low byte bits 7:5 are left as they are, software ignores them
            if (inc_i) begin
               n.lo[`PRESC_MSB:0] = q.lo[`PRESC_MSB:0] + 5'h01;
               if (q.lo[`PRESC_MSB:0] == `PRESC_ALL) begin
                  n.hi  = q.hi + 8'h01;
                  n.ovf = &q.hi;
               end
            end
         end
         MODE_16BIT: begin
            if (inc_i) begin
               {n.hi, n.lo} = {q.hi, q.lo} + 16'h0001;
               n.ovf        = &{q.hi, q.lo};
            end
         end
         MODE_RELOAD8: begin
            if (inc_i) begin
               n.lo  = (&q.lo) ? q.hi : q.lo + 8'h01;
               n.ovf = &q.lo;
            end
         end
         MODE_SPLIT: begin
            if (inc_i) begin
               n.lo  = q.lo + 8'h01;
               n.ovf = &q.lo;
            end
            if (inc_hi_i) begin
               n.hi     = q.hi + 8'h01;
               n.ovf_hi = &q.hi;
            end
         end
         default: begin
            n = q;
         end
      endcase
      // a bus write beats a count in the same cycle
      if (wr_lo_i) begin
         n.lo = wdata_i;
      end
      if (wr_hi_i) begin
         n.hi = wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '{lo: `CNT_RST, hi: `CNT_RST, ovf: 1'b0, ovf_hi: 1'b0};
      end else begin
         q <= n;
      end
   end

   assign lo_o     = q.lo;
   assign hi_o     = q.hi;
   assign ovf_o    = q.ovf;
   assign ovf_hi_o = q.ovf_hi;

endmodule

// ---- logic/dual_timer_counter_modes.sv ----
`timescale 1ns/1ps
`include "timer_map.svh"


module dual_timer_counter_modes
   import timer_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wb_req_s          wb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [1:0]  count_pin_i,
   input  wire logic [1:0]  external_gate_pin_i,
   input  wire logic [3:0]  vector_ack_i,
   output logic      [3:0]  irq_flags_o,
   output logic             irq_o,
   output logic             baud_tick_o
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      timer_run_and_irq_control_s ctl;
      timer_mode_select_reg_s     msel;
      logic [3:0]                 irq_en;
      logic [3:0]                 irq_stat;
      logic                       irq;
      logic [3:0]                 mcyc;
      logic                       tick;
      logic                       ack;
      logic [7:0]                 rdat;
      logic                       baud_tick;
   } top_s;

   top_s q, n;

   // ****************************************
   // bus decode
   // ****************************************
   logic       req;
   logic       take;
   logic       wr;
   logic [7:0] idx;
   logic [7:0] wdat;
   logic       hit_ok;
   logic [7:0] rd_data;

   // one answer per request; the ack cycle itself never takes a second one
   assign req    = wb_i.cyc & wb_i.stb;
   assign take   = req & ~q.ack;
   assign hit_ok = (wb_i.adr[1:0] == 2'b00);
   assign idx    = wb_i.adr[9:2];
   assign wr     = take & wb_i.we & wb_i.sel[0] & hit_ok;
   assign wdat   = wb_i.dat[7:0];

   // ****************************************
   // pin sampling, one per machine cycle
   // ****************************************
   logic [3:0] pins;
   logic [3:0] pin_low;
   logic [3:0] pin_fell;

   // [1:0] count inputs, [3:2] external interrupt pins
   assign pins = {external_gate_pin_i, count_pin_i};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_smp
         pin_sampler u_smp (
            .clk_i  (clk_i),
            .rst_i  (rst_i),
            .tick_i (q.tick),
            .pin_i  (pins[gi]),
            .low_o  (pin_low[gi]),
            .fell_o (pin_fell[gi])
         );
      end
   endgenerate

   // ****************************************
   // count enables
   // ****************************************
   logic split0;
   logic stop1;
   logic en0;
   logic en1;
   logic inc0;
   logic inc1;
   logic inc_hi0;

   assign split0 = (q.msel.first.mode_sel == MODE_SPLIT);
   assign stop1  = (q.msel.second.mode_sel == MODE_SPLIT);

   // gate pin read as it stands, so a gate edge takes effect at once
   assign en0 = q.ctl.first_run_bit &
                (~q.msel.first.gate_ctl | external_gate_pin_i[0]);

   // while the first timer is split, the second loses its run bit to it
   always_comb begin
      if (stop1) begin
         en1 = 1'b0;
      end else if (split0) begin
         en1 = 1'b1;
      end else begin
         en1 = q.ctl.second_run_bit &
               (~q.msel.second.gate_ctl | external_gate_pin_i[1]);
      end
   end

   // cycle or event source per counter select
   assign inc0 = en0 & (q.msel.first.counter_sel ? pin_fell[0] : q.tick);
   assign inc1 = en1 & (q.msel.second.counter_sel ? pin_fell[1] : q.tick);

   // split high byte always counts machine cycles
   assign inc_hi0 = split0 & q.ctl.second_run_bit & q.tick;

   // ****************************************
   // counters
   // ****************************************
   logic [7:0] lo0;
   logic [7:0] hi0;
   logic [7:0] lo1;
   logic [7:0] hi1;
   logic       ovf0;
   logic       ovf_hi0;
   logic       ovf1;

   count_unit u_cnt0 (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .mode_i   (q.msel.first.mode_sel),
      .inc_i    (inc0),
      .inc_hi_i (inc_hi0),
      .wr_lo_i  (wr && idx == `LO0_IDX),
      .wr_hi_i  (wr && idx == `HI0_IDX),
      .wdata_i  (wdat),
      .lo_o     (lo0),
      .hi_o     (hi0),
      .ovf_o    (ovf0),
      .ovf_hi_o (ovf_hi0)
   );

   // the second unit never runs split; its mode 3 is handled by en1
   count_unit u_cnt1 (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .mode_i   (q.msel.second.mode_sel),
      .inc_i    (inc1),
      .inc_hi_i (1'b0),
      .wr_lo_i  (wr && idx == `LO1_IDX),
      .wr_hi_i  (wr && idx == `HI1_IDX),
      .wdata_i  (wdat),
      .lo_o     (lo1),
      .hi_o     (hi1),
      .ovf_o    (ovf1),
      .ovf_hi_o ()
   );

   // ****************************************
   // events
   // ****************************************
   logic [3:0] ev;

   // the second flag belongs to the split high byte while split
   always_comb begin
      ev          = 4'h0;
      ev[`ST_OVF0] = ovf0;
      ev[`ST_OVF1] = split0 ? ovf_hi0 : ovf1;
      ev[`ST_EXA]  = q.ctl.ext_irq_a_trigger_sel ? pin_fell[2] : pin_low[2];
      ev[`ST_EXB]  = q.ctl.ext_irq_b_trigger_sel ? pin_fell[3] : pin_low[3];
   end

   // ****************************************
   // read mux
   // ****************************************
   always_comb begin
      rd_data = 8'h00;
      if (hit_ok) begin
         case (idx)
            `CTRL_IDX:     rd_data = q.ctl;
            `MODE_IDX:     rd_data = q.msel;
            `LO0_IDX:      rd_data = lo0;
            `LO1_IDX:      rd_data = lo1;
            `HI0_IDX:      rd_data = hi0;
            `HI1_IDX:      rd_data = hi1;
            `IRQ_STAT_IDX: rd_data = {4'h0, q.irq_stat};
            `IRQ_EN_IDX:   rd_data = {4'h0, q.irq_en};
            default:       rd_data = 8'h00;
         endcase
      end
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      n           = q;
      n.ack       = take;
      n.baud_tick = ovf1;
      if (take) begin
         n.rdat = rd_data;
      end

      // machine cycle strobe, one clock in twelve
      n.tick = (q.mcyc == `MCYC_LAST);
      n.mcyc = (q.mcyc == `MCYC_LAST) ? 4'h0 : q.mcyc + 4'h1;

      // mode register written whole; counts are not touched
      if (wr && idx == `MODE_IDX) begin
         n.msel = timer_mode_select_reg_s'(wdat);
      end

      // control register: run bits stored as written, counts untouched
      if (wr && idx == `CTRL_IDX) begin
         n.ctl = timer_run_and_irq_control_s'(wdat);
      end

      // vector acknowledge clears, then hardware sets win
      if (vector_ack_i[`ST_OVF0]) begin
         n.ctl.first_overflow_flag = 1'b0;
      end
      if (vector_ack_i[`ST_OVF1]) begin
         n.ctl.second_overflow_flag = 1'b0;
      end
      if (vector_ack_i[`ST_EXA]) begin
         n.ctl.ext_irq_a_pending = 1'b0;
      end
      if (vector_ack_i[`ST_EXB]) begin
         n.ctl.ext_irq_b_pending = 1'b0;
      end
      if (ev[`ST_OVF0]) begin
         n.ctl.first_overflow_flag = 1'b1;
      end
      if (ev[`ST_OVF1]) begin
         n.ctl.second_overflow_flag = 1'b1;
      end
      if (ev[`ST_EXA]) begin
         n.ctl.ext_irq_a_pending = 1'b1;
      end
      if (ev[`ST_EXB]) begin
         n.ctl.ext_irq_b_pending = 1'b1;
      end

      // interrupt enable and write-one-to-clear status
      if (wr && idx == `IRQ_EN_IDX) begin
         n.irq_en = wdat[3:0];
      end
      if (wr && idx == `IRQ_CLR_IDX) begin
         n.irq_stat = q.irq_stat & ~wdat[3:0];
      end
      n.irq_stat = n.irq_stat | ev;                                     // set beats clear
      n.irq      = |(n.irq_stat & n.irq_en);
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q.ctl       <= timer_run_and_irq_control_s'(`CTRL_RST);
         q.msel      <= timer_mode_select_reg_s'(`MODE_RST);
         q.irq_en    <= `IRQ_RST;
         q.irq_stat  <= `IRQ_RST;
         q.irq       <= 1'b0;
         q.mcyc      <= 4'h0;
         q.tick      <= 1'b0;
         q.ack       <= 1'b0;
         q.rdat      <= 8'h00;
         q.baud_tick <= 1'b0;
      end else begin
         q <= n;
      end
   end

   // ****************************************
   // outputs, all from flip-flops
   // ****************************************
   assign wb_dat_o    = {24'h000000, q.rdat};
   assign wb_ack_o    = q.ack;
   assign irq_o       = q.irq;
   assign baud_tick_o = q.baud_tick;
   assign irq_flags_o = {q.ctl.second_overflow_flag, q.ctl.first_overflow_flag,
                         q.ctl.ext_irq_b_pending, q.ctl.ext_irq_a_pending};

endmodule

// ---- test/dual_timer_counter_modes_monitor.sv ----
`timescale 1ns/1ps
`include "timer_map.svh"

module dual_timer_counter_modes_monitor
   import timer_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wb_req_s          wb_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o,
   input  wire logic [1:0]  count_pin_i,
   input  wire logic [1:0]  external_gate_pin_i,
   input  wire logic [3:0]  vector_ack_i,
   input  wire logic [3:0]  irq_flags_o,
   input  wire logic        irq_o,
   input  wire logic        baud_tick_o
);
   // ***********
   // bus decode and pin history
   // ***********
   logic       take;
   logic       wr_ctl;
   logic       wr_en_off;
   logic [3:0] fw;
   logic [5:0] hi_r [2];

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // a request is taken only while no ack is showing
   assign take      = wb_i.cyc && wb_i.stb && !wb_ack_o;
   assign wr_ctl    = take && wb_i.we && wb_i.sel[0] && wb_i.adr == {`CTRL_IDX, 2'b00};
   assign wr_en_off = take && wb_i.we && wb_i.sel[0] && wb_i.adr == {`IRQ_EN_IDX, 2'b00}
                      && wb_i.dat[3:0] == 4'h0;
   assign fw        = {wb_i.dat[7], wb_i.dat[5], wb_i.dat[3], wb_i.dat[1]};

   // high-time per gate pin; saturates so long idles never wrap
   always_ff @(posedge clk_i) begin
      for (int k = 0; k < 2; k++) begin
         if (rst_i || !external_gate_pin_i[k]) begin
            hi_r[k] <= 6'h00;
         end else if (hi_r[k] != 6'h3f) begin
            hi_r[k] <= hi_r[k] + 6'h01;
         end
      end
   end

   sequence s_take;
      take;
   endsequence
   sequence s_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   AST_ACK_NEXT: assert property (s_take |=> s_ack_once)
      else $error("request not answered by a single ack");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(take))
      else $error("ack without a request");
   AST_RSVD_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   AST_CTL_SET: assert property (wr_ctl |=> (irq_flags_o & $past(fw)) == $past(fw))
      else $error("flag written one did not stick");
   AST_BAUD_GAP: assert property (baud_tick_o |=> !baud_tick_o [*8])
      else $error("overflow ticks faster than machine cycles");
   AST_VEC_B: assert property (vector_ack_i[1] && hi_r[1] >= 6'd30 && !wr_ctl |=>
      !irq_flags_o[1])
      else $error("acknowledge did not clear pin b flag");
   AST_EDGE_A: assert property ($rose(irq_flags_o[0]) |-> hi_r[0] < 6'd30 || $past(wr_ctl))
      else $error("pin a flag rose with pin held high");
   AST_IRQ_OFF: assert property (wr_en_off |=> !irq_o)
      else $error("interrupt stayed up with all enables off");
endmodule

bind dual_timer_counter_modes dual_timer_counter_modes_monitor mon (
   .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .count_pin_i(count_pin_i), .external_gate_pin_i(external_gate_pin_i),
   .vector_ack_i(vector_ack_i), .irq_flags_o(irq_flags_o), .irq_o(irq_o),
   .baud_tick_o(baud_tick_o));

// ---- test/cpu_model.sv ----
`timescale 1ns/1ps

module cpu_model
   import timer_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   output wb_req_s          wb_o,
   output logic      [3:0]  vec_o
);
   // ***********
   // processor core side: bus cycles and vector acknowledge
   // ***********
   initial begin
      wb_o  = '0;
      vec_o = 4'h0;
   end

   // classic cycle held until ack is sampled; whole byte incl. run bits
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge clk_i);
      wb_o <= '{cyc:1'b1, stb:1'b1, we:w, adr:{idx, 2'b00}, sel:4'h1, dat:{24'h0, d}};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i[7:0];
      // released data lines show the inverse, not stale values
      wb_o <= '{cyc:1'b0, stb:1'b0, we:1'b0, adr:10'h0, sel:4'h0, dat:~{24'h0, d}};
   endtask

   // vectoring to a handler acknowledges for one cycle
   task automatic vec(input logic [3:0] m);
      @(posedge clk_i);
      vec_o <= m;
      @(posedge clk_i);
      vec_o <= 4'h0;
   endtask
endmodule

// ---- test/dual_timer_counter_modes_tb_top.sv ----
`timescale 1ns/1ps
`include "timer_map.svh"

module dual_timer_counter_modes_tb_top;
   import timer_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   wb_req_s     wb;
   logic [31:0] wb_dat;
   logic        wb_ack;
   logic        irq;
   logic        baud;
   logic [1:0]  cpin = 2'b11;
   logic [1:0]  gpin = 2'b11;
   logic [3:0]  vec;
   logic [3:0]  flags;
   logic [7:0]  q;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cyc_cnt = 0;
   int          nb = 0;

   cpu_model cpu (.clk_i(clk_i), .ack_i(wb_ack), .dat_i(wb_dat), .wb_o(wb), .vec_o(vec));
   dual_timer_counter_modes uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat),
      .wb_ack_o(wb_ack), .count_pin_i(cpin), .external_gate_pin_i(gpin),
      .vector_ack_i(vec), .irq_flags_o(flags), .irq_o(irq), .baud_tick_o(baud));

   // ***********
   // clock, watchdog and shared tasks
   // ***********
   // 40 ns period
   always #20 clk_i = ~clk_i;

   // run needs about 700 cycles; the ceiling allows plenty
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (baud === 1'b1) nb++;
      if (cyc_cnt == 5000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cpu.xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      cpu.xfer(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // bounded wait, the caller judges the flag
   task automatic wait_flag(input int b, input int lim);
      for (int i = 0; i < lim && flags[b] !== 1'b1; i++) @(posedge clk_i);
   endtask

   // ***********
   // scenarios
   // ***********
   task automatic t_regs();
      rd(`CTRL_IDX, `CTRL_RST);
      rd(`MODE_IDX, `MODE_RST);
      wr(`CTRL_IDX, 8'h50);
      rd(`CTRL_IDX, 8'h50);
      wr(`CTRL_IDX, 8'h00);
      wr(8'h99, 8'h5a);
      rd(8'h99, 8'h00);
      $display("regs done");
   endtask

   // gated off the count must hold, then a two-step 13-bit rollover
   task automatic t_mode0();
      gpin[1] <= 1'b0;
      wr(`MODE_IDX, 8'h80);
      wr(`HI1_IDX, 8'hff);
      wr(`LO1_IDX, 8'hde);
      wr(`CTRL_IDX, 8'h40);
      idle(36);
      rd(`LO1_IDX, 8'hde);
      gpin[1] <= 1'b1;
      wait_flag(3, 60);
      chk({7'h0, flags[3]}, 8'h01);
      rd(`HI1_IDX, 8'h00);
      wr(`CTRL_IDX, 8'h00);
      chk({7'h0, flags[3]}, 8'h00);
      $display("mode0 done");
   endtask

   // low byte must carry past bit 4 without touching the high byte
   task automatic t_mode1();
      wr(`MODE_IDX, 8'h01);
      wr(`HI0_IDX, 8'h00);
      wr(`LO0_IDX, 8'h1e);
      wr(`CTRL_IDX, 8'h10);
      idle(60);
      wr(`CTRL_IDX, 8'h00);
      rd(`HI0_IDX, 8'h00);
      cpu.xfer(1'b0, `LO0_IDX, 8'h00, q);
      chk({7'h0, q[5]}, 8'h01);
      $display("mode1 done");
   endtask

   task automatic t_mode2();
      wr(`MODE_IDX, 8'h02);
      wr(`HI0_IDX, 8'hfe);
      wr(`LO0_IDX, 8'hfe);
      wr(`CTRL_IDX, 8'h10);
      wait_flag(2, 60);
      chk({7'h0, flags[2]}, 8'h01);
      wr(`CTRL_IDX, 8'h20);
      rd(`HI0_IDX, 8'hfe);
      cpu.xfer(1'b0, `LO0_IDX, 8'h00, q);
      chk({1'b0, q[7:1]}, 8'h7f);
      cpu.vec(4'h4);
      idle(1);
      chk({7'h0, flags[2]}, 8'h00);
      $display("mode2 done");
   endtask

   // split timer 0; timer 1 stopped in mode 3, free-running otherwise
   task automatic t_split();
      nb = 0;
      wr(`MODE_IDX, 8'h33);
      wr(`LO1_IDX, 8'hfe);
      wr(`HI0_IDX, 8'hfe);
      wr(`CTRL_IDX, 8'h40);
      wait_flag(3, 60);
      chk({7'h0, flags[3]}, 8'h01);
      chk({7'h0, flags[2]}, 8'h00);
      chk({7'h0, nb == 0}, 8'h01);
      rd(`LO1_IDX, 8'hfe);
      // vectoring to the second timer's handler drops its flag
      cpu.vec(4'h8);
      idle(1);
      chk({7'h0, flags[3]}, 8'h00);
      wr(`CTRL_IDX, 8'h00);
      wr(`MODE_IDX, 8'h23);
      wr(`HI1_IDX, 8'hff);
      nb = 0;
      idle(60);
      chk({7'h0, nb >= 3}, 8'h01);
      chk({7'h0, flags[3]}, 8'h00);
      $display("split done");
   endtask

   // three pin pulses, each level held two machine cycles; a fourth while gated off
   task automatic t_count();
      wr(`MODE_IDX, 8'h0d);
      wr(`LO0_IDX, 8'h00);
      wr(`HI0_IDX, 8'h00);
      wr(`CTRL_IDX, 8'h10);
      repeat (3) begin
         cpin[0] <= 1'b0;
         idle(24);
         cpin[0] <= 1'b1;
         idle(24);
      end
      // gate pin low hides this fall; pin a is back high well before the irq test
      gpin[0] <= 1'b0;
      cpin[0] <= 1'b0;
      idle(24);
      cpin[0] <= 1'b1;
      gpin[0] <= 1'b1;
      idle(24);
      wr(`CTRL_IDX, 8'h00);
      rd(`LO0_IDX, 8'h03);
      $display("count done");
   endtask

   // pin a edge, pin b level; masking, acknowledge and clear
   task automatic t_irq();
      wr(`IRQ_CLR_IDX, 8'h0f);
      wr(`IRQ_EN_IDX, 8'h00);
      wr(`CTRL_IDX, 8'h01);
      gpin <= 2'b00;
      idle(40);
      chk({7'h0, flags[0]}, 8'h01);
      chk({7'h0, irq}, 8'h00);
      cpu.vec(4'h3);
      idle(1);
      chk({6'h0, flags[1:0]}, 8'h02);
      wr(`IRQ_EN_IDX, 8'h01);
      chk({7'h0, irq}, 8'h01);
      wr(`IRQ_CLR_IDX, 8'h01);
      chk({7'h0, irq}, 8'h00);
      rd(`IRQ_STAT_IDX, 8'h02);
      gpin <= 2'b11;
      idle(40);
      cpu.vec(4'h2);
      idle(1);
      chk({7'h0, flags[1]}, 8'h00);
      $display("irq done");
   endtask

   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_mode0();
      t_mode1();
      t_mode2();
      t_split();
      t_count();
      t_irq();
      end_sim();
   end
endmodule
